// ==== common/sgpc_pkg.sv ====
// Constants, register map and encodings for the switchgear position block.
package sgpc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_NS = 25;
  localparam int MS_NS = 1000000;
  // One millisecond in clock cycles, rounded up.
  localparam int TICK_CYCLES = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int TW = 16;
  localparam int PW = 16;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int DW = 32;
  localparam int AW = 8;
  localparam logic [AW-1:0] REG_CFG = 8'h00;
  localparam logic [AW-1:0] REG_CMD = 8'h04;
  localparam logic [AW-1:0] REG_STAT = 8'h08;
  localparam logic [AW-1:0] REG_TCLOSE = 8'h0c;
  localparam logic [AW-1:0] REG_TOPEN = 8'h10;
  localparam logic [AW-1:0] REG_THOLD = 8'h14;
  localparam logic [AW-1:0] REG_BO0 = 8'h18;
  localparam logic [AW-1:0] REG_STEP = 8'h04;

  // Configuration bits.
  localparam int CFG_BREAK = 0;
  localparam int CFG_CTRL = 1;
  localparam int CFG_INVIS = 2;
  localparam int CFG_EARTH = 3;
  localparam int CFG_LATCH = 4;
  localparam int CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RST = 5'h03;

  // Command register bits, write-only pulses.
  localparam int CMD_CLOSE = 0;
  localparam int CMD_OPEN = 1;
  localparam int CMD_CLR = 2;

  // Status register bits.
  localparam int ST_POS = 0;
  localparam int ST_READY = 2;
  localparam int ST_WDRAWN = 3;
  localparam int ST_CLOSE = 4;
  localparam int ST_OPEN = 5;
  localparam int ST_TRIP = 6;
  localparam int ST_SUPF = 7;
  localparam int ST_REJ = 8;

  localparam logic [TW-1:0] TCLOSE_RST = 16'h00c8;
  localparam logic [TW-1:0] TOPEN_RST = 16'h00c8;
  localparam logic [TW-1:0] THOLD_RST = 16'h0064;

  // ****************************************************************
  // Position codes
  // ****************************************************************
  localparam logic [1:0] POS_INDET = 2'h0;
  localparam logic [1:0] POS_OPEN = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_DISTURB = 2'h3;

  // ****************************************************************
  // Pin vector layout and output sources
  // ****************************************************************
  localparam int NUM_ILK = 3;
  localparam int NUM_TRIP = 4;
  localparam int NUM_BO = 4;
  localparam int NUM_SRC = 7;
  localparam int PIN_CLOSED = 0;
  localparam int PIN_OPENED = 1;
  localparam int PIN_EARTH = 2;
  localparam int PIN_READY = 3;
  localparam int PIN_WDRAWN = 4;
  localparam int PIN_EXT_CL = 5;
  localparam int PIN_EXT_OP = 6;
  localparam int PIN_ACK = 7;
  localparam int PIN_PNL_CL = 8;
  localparam int PIN_PNL_OP = 9;
  localparam int PIN_ILK_CL = 10;
  localparam int PIN_ILK_OP = PIN_ILK_CL + NUM_ILK;
  localparam int PIN_TRIP = PIN_ILK_OP + NUM_ILK;
  localparam int PIN_W = PIN_TRIP + NUM_TRIP;
  localparam int SRC_CLOSE = 0;
  localparam int SRC_OPEN = 1;
  localparam int SRC_TRIP = 2;
  localparam int SRC_READY = 3;
  localparam int SRC_WDRAWN = 4;
  localparam int SRC_SUPF = 5;
  localparam int SRC_CLOSED = 6;

  typedef enum logic [1:0] {SGPC_IDLE, SGPC_CLOSING, SGPC_OPENING} sgpc_state_t;

endpackage

// ==== hw/sgpc_top.sv ====
// Switchgear position decode, command control and trip manager.
// Behaviour
// [RULE_01] Closed-contact input true means the switchgear is closed.
// [RULE_02] Open-contact input true means the switchgear is open.
// [RULE_03] Earthing part uses the earthed contact and reports earthed when true.
// [RULE_04] Position code: 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// [RULE_05] Ready flag follows the ready input and is offered as a trigger.
// [RULE_06] Withdrawn flag follows the withdrawn input.
// [RULE_07] Separate configurable supervision times for closing and opening travel.
// [RULE_08] Each binary output ORs up to seven selectable sources.
// [RULE_09] External close and open requests come from assigned input signals.
// [RULE_10] Close commands are rejected while any close interlock is true.
// [RULE_11] Open commands are rejected while any open interlock is true.
// [RULE_12] A trip source becoming true issues an open command.
// [RULE_13] The trip command stays active at least the trip hold time.
// [RULE_14] Latch setting keeps trip after causes clear; acknowledge releases it.
// [RULE_15] Trip commands exist only for switchgear with break capability.
// [RULE_16] Break-capable but uncontrolled switchgear trips yet ignores manual commands.
// [RULE_17] Neither property: position monitored only, no commands at all.
// [RULE_18] Trips route by default to switchgear one, which has break capability.
// [RULE_19] Invisible switchgear is monitored but refuses local panel operation.
// [RULE_20] Neither end input gives indeterminate; both give disturbed.
// [RULE_21] Travel timeout withdraws the command and raises supervision failure.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
module sgpc_top #(
  parameter int TICK = sgpc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sgpc_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [sgpc_pkg::DW-1:0] wb_dat_i,
  output logic [sgpc_pkg::DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Switchgear contacts
  input wire logic aux_closed_i,
  input wire logic aux_open_i,
  input wire logic aux_earthed_i,
  input wire logic ready_i,
  input wire logic withdrawn_i,
  // Command sources
  input wire logic external_close_request_i,
  input wire logic external_open_request_i,
  input wire logic panel_close_i,
  input wire logic panel_open_i,
  input wire logic [sgpc_pkg::NUM_ILK-1:0] close_interlock_i,
  input wire logic [sgpc_pkg::NUM_ILK-1:0] open_interlock_i,
  input wire logic [sgpc_pkg::NUM_TRIP-1:0] trip_source_i,
  input wire logic trip_acknowledge_i,
  // Status and commands
  output logic [1:0] position_o,
  output logic ready_o,
  output logic withdrawn_o,
  output logic close_cmd_o,
  output logic open_cmd_o,
  output logic trip_cmd_o,
  output logic supervision_fail_o,
  output logic [sgpc_pkg::NUM_BO-1:0] binary_out_o
);
  import sgpc_pkg::*;

  localparam int TICK_W = $clog2(TICK + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK - 1);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_reg;
  logic [PIN_W-1:0] s2_reg;
  logic [PIN_W-1:0] s3_reg;
  logic [PIN_W-1:0] pin_reg;

  assign pin_raw = {trip_source_i, open_interlock_i, close_interlock_i,
                    panel_open_i, panel_close_i, trip_acknowledge_i,
                    external_open_request_i, external_close_request_i,
                    withdrawn_i, ready_i, aux_earthed_i, aux_open_i,
                    aux_closed_i};

  // A change is accepted only once the second and third stages agree.
  for (genvar gi = 0; gi < PIN_W; gi++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_reg[gi] <= 1'b0;
        s2_reg[gi] <= 1'b0;
        s3_reg[gi] <= 1'b0;
        pin_reg[gi] <= 1'b0;
      end else begin
        s1_reg[gi] <= pin_raw[gi];
        s2_reg[gi] <= s1_reg[gi];
        s3_reg[gi] <= s2_reg[gi];
        if (s2_reg[gi] == s3_reg[gi]) begin
          pin_reg[gi] <= s3_reg[gi];
        end
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [CFG_W-1:0] cfg_reg;
  logic [TW-1:0] tclose_reg;
  logic [TW-1:0] topen_reg;
  logic [TW-1:0] thold_reg;
  logic [NUM_SRC-1:0] bo_sel_reg [NUM_BO];
  logic sw_close_reg;
  logic sw_open_reg;
  logic sw_clr_reg;
  logic rej_reg;
  logic wb_req;
  logic wb_wr;
  logic [DW-1:0] rd_data;
  logic [DW-1:0] cfg_mrg;
  logic [DW-1:0] tclose_mrg;
  logic [DW-1:0] topen_mrg;
  logic [DW-1:0] thold_mrg;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                          input logic [DW-1:0] dat,
                                          input logic [3:0] sel);
    logic [DW-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Lanes are merged at full bus width and cut where each register is stored.
  assign cfg_mrg = merge(DW'(cfg_reg), wb_dat_i, wb_sel_i);
  assign tclose_mrg = merge(DW'(tclose_reg), wb_dat_i, wb_sel_i);
  assign topen_mrg = merge(DW'(topen_reg), wb_dat_i, wb_sel_i);
  assign thold_mrg = merge(DW'(thold_reg), wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= CFG_RST;
      tclose_reg <= TCLOSE_RST;
      topen_reg <= TOPEN_RST;
      thold_reg <= THOLD_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        REG_CFG: cfg_reg <= cfg_mrg[CFG_W-1:0];
        REG_TCLOSE: tclose_reg <= tclose_mrg[TW-1:0]; // [RULE_07]
        REG_TOPEN: topen_reg <= topen_mrg[TW-1:0]; // [RULE_07]
        REG_THOLD: thold_reg <= thold_mrg[TW-1:0];
        default: ;
      endcase
    end
  end

  for (genvar gb = 0; gb < NUM_BO; gb++) begin : g_bo_reg
    localparam logic [AW-1:0] BO_ADR = AW'(REG_BO0 + gb * REG_STEP);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bo_sel_reg[gb] <= '0;
      end else if (wb_wr && wb_adr_i == BO_ADR && wb_sel_i[0]) begin
        bo_sel_reg[gb] <= wb_dat_i[NUM_SRC-1:0];
      end
    end
  end

  // Command writes become one-cycle pulses.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_close_reg <= 1'b0;
      sw_open_reg <= 1'b0;
      sw_clr_reg <= 1'b0;
    end else begin
      sw_close_reg <= wb_wr & (wb_adr_i == REG_CMD) & wb_sel_i[0] &
                      wb_dat_i[CMD_CLOSE];
      sw_open_reg <= wb_wr & (wb_adr_i == REG_CMD) & wb_sel_i[0] &
                     wb_dat_i[CMD_OPEN];
      sw_clr_reg <= wb_wr & (wb_adr_i == REG_CMD) & wb_sel_i[0] &
                    wb_dat_i[CMD_CLR];
    end
  end

  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      REG_CFG: rd_data[CFG_W-1:0] = cfg_reg;
      REG_STAT: begin
        rd_data[ST_POS +: 2] = position_o;
        rd_data[ST_READY] = ready_o;
        rd_data[ST_WDRAWN] = withdrawn_o;
        rd_data[ST_CLOSE] = close_cmd_o;
        rd_data[ST_OPEN] = open_cmd_o;
        rd_data[ST_TRIP] = trip_cmd_o;
        rd_data[ST_SUPF] = supervision_fail_o;
        rd_data[ST_REJ] = rej_reg;
      end
      REG_TCLOSE: rd_data[TW-1:0] = tclose_reg;
      REG_TOPEN: rd_data[TW-1:0] = topen_reg;
      REG_THOLD: rd_data[TW-1:0] = thold_reg;
      default: begin
        for (int k = 0; k < NUM_BO; k++) begin
          if (wb_adr_i == AW'(REG_BO0 + k * REG_STEP)) begin
            rd_data[NUM_SRC-1:0] = bo_sel_reg[k];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_req) begin
      wb_dat_o <= rd_data;
    end
  end

  // ****************************************************************
  // Position and status
  // ****************************************************************
  logic closed_in;
  logic [1:0] pos_next;

  // An earthing part reports its earthed contact as the end position.
  assign closed_in = cfg_reg[CFG_EARTH] ? pin_reg[PIN_EARTH] // [RULE_03]
                                        : pin_reg[PIN_CLOSED]; // [RULE_01]

  always_comb begin
    case ({closed_in, pin_reg[PIN_OPENED]})
      2'b10: pos_next = POS_CLOSED; // [RULE_01]
      2'b01: pos_next = POS_OPEN; // [RULE_02]
      2'b11: pos_next = POS_DISTURB; // [RULE_20]
      default: pos_next = POS_INDET; // [RULE_04]
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      position_o <= POS_INDET;
      ready_o <= 1'b0;
      withdrawn_o <= 1'b0;
    end else begin
      position_o <= pos_next; // [RULE_04]
      ready_o <= pin_reg[PIN_READY]; // [RULE_05]
      withdrawn_o <= pin_reg[PIN_WDRAWN]; // [RULE_06]
    end
  end

  // ****************************************************************
  // Manual and external commands
  // ****************************************************************
  sgpc_state_t state_reg;
  logic [3:0] req_prev_reg;
  logic [3:0] req_now;
  logic [3:0] req_rise;
  logic close_req;
  logic open_req;
  logic close_ilk;
  logic open_ilk;
  logic close_go;
  logic open_go;
  logic [TICK_W-1:0] mv_pre_reg;
  logic [TW-1:0] mv_ms_reg;
  logic mv_timeout;

  // Level inputs act on their rising edge so a held request cannot retry.
  assign req_now = {pin_reg[PIN_PNL_OP], pin_reg[PIN_PNL_CL],
                    pin_reg[PIN_EXT_OP], pin_reg[PIN_EXT_CL]};
  assign req_rise = req_now & ~req_prev_reg;
  assign close_req = cfg_reg[CFG_CTRL] & // [RULE_16] [RULE_17]
                     (sw_close_reg | req_rise[0] | // [RULE_09]
                      (~cfg_reg[CFG_INVIS] & req_rise[2])); // [RULE_19]
  assign open_req = cfg_reg[CFG_CTRL] & // [RULE_16] [RULE_17]
                    (sw_open_reg | req_rise[1] | // [RULE_09]
                     (~cfg_reg[CFG_INVIS] & req_rise[3])); // [RULE_19]
  assign close_ilk = |pin_reg[PIN_ILK_CL +: NUM_ILK];
  assign open_ilk = |pin_reg[PIN_ILK_OP +: NUM_ILK];
  assign close_go = close_req & ~close_ilk & ~open_req; // [RULE_10]
  assign open_go = open_req & ~open_ilk; // [RULE_11]
  assign mv_timeout = (mv_pre_reg == TICK_LAST) &&
                      (mv_ms_reg + 1'b1 >= ((state_reg == SGPC_CLOSING) ?
                                            tclose_reg : topen_reg));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_prev_reg <= '0;
    end else begin
      req_prev_reg <= req_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SGPC_IDLE;
    end else begin
      case (state_reg)
        SGPC_IDLE: begin
          if (open_go && !trip_cmd_o) begin
            state_reg <= SGPC_OPENING;
          end else if (close_go && !trip_cmd_o) begin
            state_reg <= SGPC_CLOSING;
          end
        end
        SGPC_CLOSING: begin
          // A trip always aborts a closing travel.
          if (trip_cmd_o || pos_next == POS_CLOSED || mv_timeout) begin
            state_reg <= SGPC_IDLE; // [RULE_21]
          end
        end
        SGPC_OPENING: begin
          if (pos_next == POS_OPEN || mv_timeout) begin
            state_reg <= SGPC_IDLE; // [RULE_21]
          end
        end
        default: state_reg <= SGPC_IDLE;
      endcase
    end
  end

  // Travel timer restarts with each travel so the allowed time is whole.
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == SGPC_IDLE) begin
      mv_pre_reg <= '0;
      mv_ms_reg <= '0;
    end else if (mv_pre_reg == TICK_LAST) begin
      mv_pre_reg <= '0;
      mv_ms_reg <= mv_ms_reg + 1'b1; // [RULE_07]
    end else begin
      mv_pre_reg <= mv_pre_reg + 1'b1;
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supervision_fail_o <= 1'b0;
      rej_reg <= 1'b0;
    end else begin
      supervision_fail_o <= (state_reg != SGPC_IDLE && mv_timeout &&
                             !(state_reg == SGPC_CLOSING && trip_cmd_o)) |
                            (supervision_fail_o & ~sw_clr_reg); // [RULE_21]
      rej_reg <= (close_req & close_ilk) | (open_req & open_ilk) |
                 (rej_reg & ~sw_clr_reg); // [RULE_10] [RULE_11]
    end
  end

  // ****************************************************************
  // Trip manager
  // ****************************************************************
  logic [NUM_TRIP-1:0] trip_prev_reg;
  logic trip_go;
  logic trip_hold_done;
  logic ack_seen_reg;
  logic [TICK_W-1:0] tr_pre_reg;
  logic [TW-1:0] tr_ms_reg;
  logic trip_release;

  // This block is switchgear one, the default destination of trips.
  assign trip_go = cfg_reg[CFG_BREAK] & // [RULE_15] [RULE_18]
                   (|(pin_reg[PIN_TRIP +: NUM_TRIP] & ~trip_prev_reg));
  assign trip_hold_done = (tr_ms_reg >= thold_reg);
  assign trip_release = trip_hold_done & // [RULE_13]
                        ~(|pin_reg[PIN_TRIP +: NUM_TRIP]) &
                        (~cfg_reg[CFG_LATCH] | ack_seen_reg); // [RULE_14]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_prev_reg <= '0;
      trip_cmd_o <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      trip_prev_reg <= pin_reg[PIN_TRIP +: NUM_TRIP];
      if (trip_go) begin
        trip_cmd_o <= 1'b1; // [RULE_12]
        ack_seen_reg <= 1'b0;
      end else if (trip_cmd_o && trip_release) begin
        trip_cmd_o <= 1'b0;
        ack_seen_reg <= 1'b0;
      end else if (trip_cmd_o && pin_reg[PIN_ACK]) begin
        ack_seen_reg <= 1'b1; // [RULE_14]
      end
    end
  end

  // Hold timer restarts on every new trip edge.
  always_ff @(posedge clk_i) begin
    if (rst_i || trip_go || !trip_cmd_o) begin
      tr_pre_reg <= '0;
      tr_ms_reg <= '0;
    end else if (!trip_hold_done) begin
      if (tr_pre_reg == TICK_LAST) begin
        tr_pre_reg <= '0;
        tr_ms_reg <= tr_ms_reg + 1'b1; // [RULE_13]
      end else begin
        tr_pre_reg <= tr_pre_reg + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Command and binary outputs
  // ****************************************************************
  logic [NUM_SRC-1:0] src;

  assign close_cmd_o = (state_reg == SGPC_CLOSING);
  assign open_cmd_o = (state_reg == SGPC_OPENING) | trip_cmd_o; // [RULE_12]
  assign src = {position_o == POS_CLOSED, supervision_fail_o,
                withdrawn_o, ready_o, trip_cmd_o, open_cmd_o, close_cmd_o};

  for (genvar go = 0; go < NUM_BO; go++) begin : g_bo_out
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        binary_out_o[go] <= 1'b0;
      end else begin
        binary_out_o[go] <= |(bo_sel_reg[go] & src); // [RULE_08]
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pos_closed_a: assert property ( // [RULE_01]
    !cfg_reg[CFG_EARTH] && pin_reg[PIN_CLOSED] && !pin_reg[PIN_OPENED]
    |=> position_o == POS_CLOSED)
    else $error("closed contact not reported as closed");
  pos_both_a: assert property ( // [RULE_20]
    closed_in && pin_reg[PIN_OPENED] |=> position_o == POS_DISTURB)
    else $error("both contacts not reported as disturbed");
  ready_follow_a: assert property ( // [RULE_05]
    $rose(pin_reg[PIN_READY]) |=> ready_o)
    else $error("ready flag did not follow input");
  close_ilk_a: assert property ( // [RULE_10]
    state_reg == SGPC_IDLE && close_ilk |=> state_reg != SGPC_CLOSING)
    else $error("close started under interlock");
  open_ilk_a: assert property ( // [RULE_11]
    state_reg == SGPC_IDLE && open_ilk |=> state_reg != SGPC_OPENING)
    else $error("open started under interlock");
  trip_hold_a: assert property ( // [RULE_13]
    $fell(trip_cmd_o) |-> $past(trip_hold_done))
    else $error("trip released before hold time");
  trip_latch_a: assert property ( // [RULE_14]
    trip_cmd_o && cfg_reg[CFG_LATCH] && !ack_seen_reg && !pin_reg[PIN_ACK]
    |=> trip_cmd_o)
    else $error("latched trip released without acknowledge");
  trip_break_a: assert property ( // [RULE_15]
    !cfg_reg[CFG_BREAK] && !trip_cmd_o |=> !trip_cmd_o)
    else $error("trip raised without break capability");
  manual_block_a: assert property ( // [RULE_16]
    !cfg_reg[CFG_CTRL] && state_reg == SGPC_IDLE |=> !close_cmd_o)
    else $error("manual close on uncontrolled switchgear");
  travel_fail_a: assert property ( // [RULE_21]
    $rose(supervision_fail_o) |-> $past(state_reg) != SGPC_IDLE
    && state_reg == SGPC_IDLE)
    else $error("supervision failure without withdrawn travel");

endmodule

// ==== test/sgpc_sg_model.sv ====
// Behavioural switchgear drive with auxiliary contacts.
module sgpc_sg_model #(
  parameter int DLY = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Commands and test controls
  input wire logic close_cmd_i,
  input wire logic open_cmd_i,
  input wire logic stall_i,
  input wire logic fault_i,
  // Contacts
  output logic aux_closed_o,
  output logic aux_open_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic shut;
  logic moving;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      shut <= 1'b0;
    end else if ((close_cmd_i || open_cmd_i) && !stall_i) begin
      cnt <= (cnt < DLY) ? cnt + 1 : cnt;
      if (cnt == DLY - 1) begin
        shut <= close_cmd_i && !open_cmd_i;
      end
    end else begin
      cnt <= 0;
    end
  end
  // A stalled drive never leaves travel, so both contacts stay open.
  assign moving = (close_cmd_i || open_cmd_i) && (stall_i || cnt < DLY);
  assign aux_closed_o = fault_i || (!moving && shut);
  assign aux_open_o = fault_i || (!moving && !shut);
endmodule

// ==== test/sgpc_top_tb.sv ====
// Self-checking bench for the switchgear position and command block.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module sgpc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sgpc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [AW-1:0] adr = '0;
  logic [3:0] sel = '0;
  logic [DW-1:0] wdat = '0, rdat, rd;
  logic ecl = 0, eop = 0, ack = 0, rdy = 0, wdr = 0, stall = 0, fault = 0;
  logic ear = 0, pcl = 0, pop = 0;
  logic [NUM_ILK-1:0] icl = '0, iop = '0;
  logic [NUM_TRIP-1:0] trp = '0;
  logic [1:0] pos;
  logic wack, rdy_o, wdr_o, ccmd, ocmd, tcmd, supf, acl, aop;
  logic [NUM_BO-1:0] bo;
  int errors = 0, num_checks = 0, cycles = 0, k;
  sgpc_top #(.TICK(4)) sgpc_top_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(wack),
    .aux_closed_i(acl), .aux_open_i(aop), .aux_earthed_i(ear),
    .ready_i(rdy), .withdrawn_i(wdr), .external_close_request_i(ecl),
    .external_open_request_i(eop), .panel_close_i(pcl),
    .panel_open_i(pop), .close_interlock_i(icl), .open_interlock_i(iop),
    .trip_source_i(trp), .trip_acknowledge_i(ack), .position_o(pos),
    .ready_o(rdy_o), .withdrawn_o(wdr_o), .close_cmd_o(ccmd),
    .open_cmd_o(ocmd), .trip_cmd_o(tcmd), .supervision_fail_o(supf),
    .binary_out_o(bo));
  sgpc_sg_model sgpc_sg_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .close_cmd_i(ccmd), .open_cmd_i(ocmd), .stall_i(stall),
    .fault_i(fault), .aux_closed_o(acl), .aux_open_o(aop));
  // ****************
  // Helpers
  // ****************
  function automatic logic [1:0] pos_of(input logic c, input logic o);
    return (c && o) ? POS_DISTURB : c ? POS_CLOSED : o ? POS_OPEN : POS_INDET;
  endfunction
  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [DW-1:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk_i); while (wack !== 1'b1);
    rdat = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic trip_pulse();
    k = $urandom % NUM_TRIP;
    trp[k] <= 1'b1;
    wt(10);
    trp[k] <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(32'h5ec03a66));
    wt(5);
    rst_i <= 1'b0;
    wt(8);
    `CHK("pos", pos_of(acl, aop), pos)
    bus(1'b0, REG_CFG, '0);
    `CHK("cfg", 32'h3, rdat)
    bus(1'b0, 8'hfc, '0);
    `CHK("unmapped", 32'h0, rdat)
    bus(1'b1, REG_BO0, 32'h8);
    for (int i = 0; i < 4; i++) begin
      rdy <= 1'($urandom);
      wdr <= 1'($urandom);
      wt(8);
      `CHK("ready", rdy, rdy_o)
      `CHK("withdrawn", wdr, wdr_o)
      `CHK("bo0", rdy, bo[0])
    end
    icl <= 3'(1 << ($urandom % NUM_ILK));
    wt(8);
    bus(1'b1, REG_CMD, 32'h1);
    wt(4);
    `CHK("close rej", 1'b0, ccmd)
    bus(1'b0, REG_STAT, '0);
    `CHK("reject", 1'b1, rdat[ST_REJ])
    icl <= '0;
    bus(1'b1, REG_TCLOSE, 32'h5);
    bus(1'b1, REG_THOLD, 32'ha);
    wt(8);
    bus(1'b1, REG_CMD, 32'h1);
    wt(1);
    `CHK("close cmd", 1'b1, ccmd)
    wt(30);
    `CHK("closed", POS_CLOSED, pos)
    `CHK("close done", 1'b0, ccmd)
    fault <= 1'b1;
    wt(8);
    `CHK("disturbed", pos_of(acl, aop), pos)
    fault <= 1'b0;
    iop <= 3'(1 << ($urandom % NUM_ILK));
    wt(8);
    eop <= 1'b1;
    wt(8);
    `CHK("open rej", 1'b0, ocmd)
    eop <= 1'b0;
    iop <= '0;
    wt(8);
    eop <= 1'b1;
    wt(12);
    `CHK("open cmd", 1'b1, ocmd)
    `CHK("travel", POS_INDET, pos)
    eop <= 1'b0;
    wt(30);
    `CHK("opened", POS_OPEN, pos)
    bus(1'b1, REG_CFG, 32'h7);
    pcl <= 1'b1;
    pop <= 1'b1;
    wt(8);
    `CHK("invisible", 2'b00, {ccmd, ocmd})
    pcl <= 1'b0;
    pop <= 1'b0;
    bus(1'b1, REG_CFG, 32'h3);
    wt(6);
    pcl <= 1'b1;
    wt(8);
    `CHK("panel", 1'b1, ccmd)
    pcl <= 1'b0;
    wt(30);
    bus(1'b1, REG_CFG, 32'hb);
    ear <= 1'b1;
    wt(8);
    `CHK("earthed", POS_CLOSED, pos)
    ear <= 1'b0;
    wt(8);
    `CHK("earth only", POS_INDET, pos)
    bus(1'b1, REG_CFG, 32'h3);
    bus(1'b1, REG_CMD, 32'h2);
    wt(1);
    `CHK("reg open", 1'b1, ocmd)
    wt(30);
    `CHK("reopened", POS_OPEN, pos)
    stall <= 1'b1;
    ecl <= 1'b1;
    wt(40);
    `CHK("sup fail", 1'b1, supf)
    `CHK("cmd dropped", 1'b0, ccmd)
    stall <= 1'b0;
    ecl <= 1'b0;
    bus(1'b1, REG_CMD, 32'h4);
    wt(2);
    `CHK("cleared", 1'b0, supf)
    trip_pulse();
    `CHK("trip", 1'b1, tcmd)
    `CHK("trip open", 1'b1, ocmd)
    wt(20);
    `CHK("trip hold", 1'b1, tcmd)
    wt(40);
    `CHK("trip off", 1'b0, tcmd)
    bus(1'b1, REG_CFG, 32'h13);
    trip_pulse();
    wt(80);
    `CHK("latched", 1'b1, tcmd)
    ack <= 1'b1;
    wt(10);
    ack <= 1'b0;
    wt(4);
    `CHK("acked", 1'b0, tcmd)
    bus(1'b1, REG_CFG, 32'h2);
    trip_pulse();
    `CHK("no break", 1'b0, tcmd)
    bus(1'b1, REG_CFG, 32'h1);
    bus(1'b1, REG_CMD, 32'h1);
    wt(2);
    `CHK("uncontrolled", 1'b0, ccmd)
    trip_pulse();
    `CHK("trip only", 1'b1, tcmd)
    wt(60);
    bus(1'b1, REG_CFG, 32'h0);
    bus(1'b1, REG_CMD, 32'h1);
    trip_pulse();
    `CHK("monitor", 2'b00, {ccmd, tcmd})
    end_of_test();
  end
endmodule
